// *** src/sls_pkg.sv ***
// sls_pkg: constants and types of the speed-loop gain and tuning block.
// assumes a 20 MHz clock and a 16-bit parameter port with 12-bit addresses.
package sls_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // parameter addresses
   localparam logic [11:0] ADDR_KP = 12'h208;
   localparam logic [11:0] ADDR_KI = 12'h20c;
   localparam logic [11:0] ADDR_KF = 12'h20e;
   localparam logic [11:0] ADDR_MODE = 12'h240;
   localparam logic [11:0] ADDR_INERTIA = 12'h300;
   localparam logic [11:0] ADDR_STABLE = 12'h302;
   localparam logic [11:0] ADDR_STIFF = 12'h304;
   localparam logic [11:0] ADDR_FIRST = 12'h306;
   localparam logic [11:0] ADDR_LPF = 12'h308;
   localparam logic [11:0] ADDR_EXTRA2 = 12'h30a;
   localparam logic [11:0] ADDR_STAB_THR = 12'h30c;
   localparam logic [11:0] ADDR_RANGE_THR = 12'h30e;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h310;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h312;
   localparam logic [11:0] ADDR_EST = 12'h314;
   ////////////////////////////////////////////////////////////////////////////
   // reset values and limits
   localparam logic [15:0] KP_RST = 16'h01f4;
   localparam logic [15:0] KI_RST = 16'h0064;
   localparam logic [15:0] KF_RST = 16'h0000;
   localparam logic [15:0] INERTIA_RST = 16'h000a;
   localparam logic [15:0] STIFF_RST = 16'h0010;
   localparam logic [15:0] LPF_RST = 16'h0002;
   localparam logic [15:0] STAB_THR_RST = 16'h0004;
   localparam logic [15:0] RANGE_THR_RST = 16'h0040;
   localparam logic [15:0] KP_MAX = 16'h1fff;
   localparam logic [15:0] KI_MAX = 16'h03ff;
   localparam logic [15:0] KF_MAX = 16'h0064;
   localparam logic [15:0] MODE_MAX = 16'h0002;
   ////////////////////////////////////////////////////////////////////////////
   // interrupt bit positions
   localparam int IRQ_STABLE = 0;
   localparam int IRQ_RANGE = 1;
   localparam int IRQ_SAVED = 2;
   localparam int IRQ_UPDATED = 3;
   localparam int IRQ_W = 4;
   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam longint CLK_HZ = 64'd20_000_000;
   localparam longint SAVE_MINUTES = 64'd30;
   localparam longint SAVE_CYCLES = SAVE_MINUTES * 64'd60 * CLK_HZ;
   localparam logic [3:0] STABLE_SAMPLES = 4'h8;
   localparam int PI_SHIFT = 8;
   localparam int ACC_SHIFT = 10;
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {SLS_MANUAL, SLS_AUTO, SLS_SEMI} sls_mode_t;
   typedef enum logic {SLS_EST_RUN, SLS_EST_HOLD} sls_est_t;
endpackage : sls_pkg

// *** src/sls_gain_if.sv ***
// sls_gain_if: active gains and run enable handed to the speed controller.
// assumes one clock domain; the tuning top drives, the controller reads.
`timescale 1ns/1ps
interface sls_gain_if;
   logic [15:0] kp;
   logic [15:0] ki;
   logic [15:0] kf;
   logic run;
   modport src (output kp, output ki, output kf, output run);
   modport dst (input kp, input ki, input kf, input run);
endinterface : sls_gain_if

// *** src/sls_cmd_sel.sv ***
// sls_cmd_sel: chooses the active speed command from the two select inputs.
// assumes select inputs and analog sample are synchronous to clk_i.
`timescale 1ns/1ps
module sls_cmd_sel (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic drive_en_i,
   input wire logic speed_select_low_i,
   input wire logic speed_select_high_i,
   input wire logic signed [15:0] analog_speed_i,
   output logic signed [15:0] selected_speed_command_o,
   output logic zero_speed_mode_o
);
   logic zero_speed_mode;
   // both selects open is the zero-speed mode, any other code takes analog
   assign zero_speed_mode = !speed_select_low_i && !speed_select_high_i;
   // command held at zero while the drive is off, so no jump at enable
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         selected_speed_command_o <= 16'sh0000;
         zero_speed_mode_o <= 1'b1;
      end else if (ce_i) begin
         zero_speed_mode_o <= zero_speed_mode;
         if (!drive_en_i || zero_speed_mode) begin
            selected_speed_command_o <= 16'sh0000;
         end else begin
            selected_speed_command_o <= analog_speed_i;
         end
      end
   end
endmodule : sls_cmd_sel

// *** src/sls_pi.sv ***
// sls_pi: speed controller, proportional plus integral plus feed-forward.
// assumes gains arrive already clamped to their legal ranges.
`timescale 1ns/1ps
module sls_pi
   import sls_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   sls_gain_if.dst gain,
   input wire logic signed [15:0] cmd_i,
   input wire logic signed [15:0] fb_i,
   output logic signed [15:0] out_o
);
   logic signed [16:0] err;
   logic signed [31:0] acc_q;
   logic signed [55:0] sum;
   logic signed [55:0] scaled;
   logic sat;
   assign err = 17'(cmd_i) - 17'(fb_i);
   // three terms; feed-forward gain is a percentage of the command
   assign sum = 56'(err) * 56'(signed'({1'b0, gain.kp}))
      + 56'(acc_q >>> ACC_SHIFT) * 56'(signed'({1'b0, gain.ki}))
      + (56'(cmd_i) * 56'(signed'({1'b0, gain.kf})) * 56'sd256) / 56'sd100;
   assign scaled = sum >>> PI_SHIFT;
   assign sat = (scaled > 56'sd32767) || (scaled < -56'sd32768);
   // integrator freezes while saturated to stop wind-up
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_q <= 32'sh0;
      end else if (ce_i) begin
         if (!gain.run) begin
            acc_q <= 32'sh0;
         end else if (!sat) begin
            acc_q <= acc_q + 32'(err);
         end
      end
   end
   // output saturates to the signed 16-bit range
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_o <= 16'sh0000;
      end else if (ce_i) begin
         if (!gain.run) begin
            out_o <= 16'sh0000;
         end else if (scaled > 56'sd32767) begin
            out_o <= 16'sh7fff;
         end else if (scaled < -56'sd32768) begin
            out_o <= 16'sh8000;
         end else begin
            out_o <= 16'(scaled);
         end
      end
   end
endmodule : sls_pi

// *** src/sls_tune_top.sv ***
// sls_tune_top: speed-loop gains, tuning mode control and inertia tracking.
// assumes a 16-bit parameter port and inertia samples from the feedback path.
//
// Overview of operation
// - tuning mode takes 0 manual, 1 continuous auto, 2 semi-auto only
// - in manual mode every gain parameter is user writable
// - manual mode disables automatic gain changes entirely
// - continuous auto saves estimated inertia every 30 minutes
// - leaving auto or semi-auto to manual stores inertia and sets gains
// - auto to manual overwrites first gain, proportional and integral gains
// - semi to manual also overwrites low-pass time and second extra gain
// - semi-auto stable inertia sets flag, stops estimating, saves inertia
// - semi-auto out-of-range inertia clears flag and resumes estimation
// - entering semi-auto from another mode restarts inertia estimation
// - proportional gain is 16 bits, 0 to 8191, reset 500
// - integral gain is 16 bits, 0 to 1023, reset 100
// - feed-forward gain is a percentage, at most 100
// - zero-speed mode forces command 0, otherwise analog input
// - while enabled the command follows the two speed selects
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module sls_tune_top
   import sls_pkg::*;
#(
   parameter longint SAVE_CYC = SAVE_CYCLES
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [11:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic drive_en_i,
   input wire logic speed_select_low_i,
   input wire logic speed_select_high_i,
   input wire logic signed [15:0] analog_speed_i,
   input wire logic signed [15:0] speed_fb_i,
   input wire logic [15:0] inertia_sample_i,
   input wire logic inertia_valid_i,
   output logic signed [15:0] speed_out_o,
   output logic signed [15:0] selected_speed_command_o,
   output logic zero_speed_mode_o,
   output logic semi_auto_stable_flag_o,
   output logic irq_o
);
   sls_mode_t mode_q;
   sls_est_t est_st_q;
   logic [15:0] kp_q, ki_q, kf_q, first_q, lpf_q, extra2_q;
   logic [15:0] inertia_q, est_q, stiff_q, stab_thr_q, range_thr_q;
   logic [3:0] stab_cnt_q;
   logic [35:0] save_cnt_q;
   logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
   logic stable_q;
   logic wr_ok, manual, mode_wr, to_manual, to_semi, to_auto;
   logic sample_ok, est_step, near, out_range, go_stable, timer_save;
   sls_mode_t new_mode;
   logic [15:0] auto_kp, auto_ki, auto_lpf, auto_extra2;
   logic signed [16:0] est_diff;
   sls_gain_if gain_bus ();

   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
      clamp16 = (v > lim) ? lim : v;
   endfunction : clamp16

   function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
      absdiff = (a > b) ? (a - b) : (b - a);
   endfunction : absdiff

   ////////////////////////////////////////////////////////////////////////////
   // decode of writes and mode transitions
   assign wr_ok = ce_i && wr_i;
   assign manual = (mode_q == SLS_MANUAL);
   assign new_mode = sls_mode_t'(wdata_i[1:0]);
   assign mode_wr = wr_ok && (addr_i == ADDR_MODE) && (wdata_i <= MODE_MAX);
   assign to_manual = mode_wr && (new_mode == SLS_MANUAL) && !manual;
   assign to_semi = mode_wr && (new_mode == SLS_SEMI) && (mode_q != SLS_SEMI);
   assign to_auto = mode_wr && (new_mode == SLS_AUTO) && (mode_q != SLS_AUTO);

   // gains produced by tuning, from estimate and stiffness level
   assign auto_kp = clamp16(16'((32'(stiff_q) << 4) + 32'(est_q >> 2)), KP_MAX);
   assign auto_ki = clamp16(auto_kp >> 2, KI_MAX);
   assign auto_lpf = 16'((est_q >> 4) + 16'h0001);
   assign auto_extra2 = auto_kp >> 1;

   ////////////////////////////////////////////////////////////////////////////
   // estimator step conditions; thresholds come from software
   assign sample_ok = ce_i && inertia_valid_i && !manual && !mode_wr;
   assign est_step = sample_ok && ((mode_q == SLS_AUTO) || (est_st_q == SLS_EST_RUN));
   assign est_diff = 17'({1'b0, inertia_sample_i}) - 17'({1'b0, est_q});
   assign near = absdiff(inertia_sample_i, est_q) <= stab_thr_q;
   assign out_range = absdiff(inertia_sample_i, inertia_q) > range_thr_q;
   assign go_stable = est_step && (mode_q == SLS_SEMI) && near
      && (stab_cnt_q == STABLE_SAMPLES - 4'h1);
   assign timer_save = ce_i && (mode_q == SLS_AUTO) && !mode_wr
      && (save_cnt_q == 36'(SAVE_CYC - 64'd1));

   ////////////////////////////////////////////////////////////////////////////
   // tuning mode register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mode_q <= SLS_MANUAL;
      end else if (mode_wr) begin
         mode_q <= new_mode;
      end
   end

   // speed gains: user writes only in manual, tuning results on exit
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         kp_q <= KP_RST;
         ki_q <= KI_RST;
         kf_q <= KF_RST;
         first_q <= KP_RST;
         lpf_q <= LPF_RST;
         extra2_q <= 16'h0000;
      end else if (to_manual) begin
         kp_q <= auto_kp;
         ki_q <= auto_ki;
         first_q <= auto_kp;
         if (mode_q == SLS_SEMI) begin
            lpf_q <= auto_lpf;
            extra2_q <= auto_extra2;
         end
      end else if (wr_ok && manual) begin
         unique case (addr_i)
            ADDR_KP: kp_q <= clamp16(wdata_i, KP_MAX);
            ADDR_KI: ki_q <= clamp16(wdata_i, KI_MAX);
            ADDR_KF: kf_q <= clamp16(wdata_i, KF_MAX);
            ADDR_FIRST: first_q <= wdata_i;
            ADDR_LPF: lpf_q <= wdata_i;
            ADDR_EXTRA2: extra2_q <= wdata_i;
            default: ;
         endcase
      end
   end

   // settings that stay writable in every mode
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stiff_q <= STIFF_RST;
         stab_thr_q <= STAB_THR_RST;
         range_thr_q <= RANGE_THR_RST;
         irq_mask_q <= '0;
      end else if (wr_ok) begin
         unique case (addr_i)
            ADDR_STIFF: stiff_q <= wdata_i;
            ADDR_STAB_THR: stab_thr_q <= wdata_i;
            ADDR_RANGE_THR: range_thr_q <= wdata_i;
            ADDR_IRQ_MASK: irq_mask_q <= wdata_i[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // inertia ratio: user value, periodic save, stable save, exit save
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         inertia_q <= INERTIA_RST;
      end else if (to_manual || timer_save || go_stable) begin
         inertia_q <= est_q;
      end else if (wr_ok && (addr_i == ADDR_INERTIA)) begin
         inertia_q <= wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // periodic save timer; 36 bits hold the half-hour count at 20 MHz
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         save_cnt_q <= '0;
      end else if (ce_i) begin
         if (mode_q != SLS_AUTO || mode_wr || timer_save) begin
            save_cnt_q <= '0;
         end else begin
            save_cnt_q <= save_cnt_q + 36'h1;
         end
      end
   end

   // estimate seeded from the stored ratio when tuning starts
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         est_q <= INERTIA_RST;
      end else if (to_semi || to_auto) begin
         est_q <= inertia_q;
      end else if (est_step) begin
         est_q <= est_q + 16'(est_diff >>> 3);
      end
   end

   // semi-auto estimation state and stable flag
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         est_st_q <= SLS_EST_RUN;
         stable_q <= 1'b0;
         stab_cnt_q <= '0;
      end else if (to_semi || to_auto || to_manual) begin
         est_st_q <= SLS_EST_RUN;
         stable_q <= 1'b0;
         stab_cnt_q <= '0;
      end else if (sample_ok && mode_q == SLS_SEMI) begin
         unique case (est_st_q)
            SLS_EST_RUN: begin
               if (go_stable) begin
                  est_st_q <= SLS_EST_HOLD;
                  stable_q <= 1'b1;
                  stab_cnt_q <= '0;
               end else if (near) begin
                  stab_cnt_q <= stab_cnt_q + 4'h1;
               end else begin
                  stab_cnt_q <= '0;
               end
            end
            SLS_EST_HOLD: begin
               if (out_range) begin
                  est_st_q <= SLS_EST_RUN;
                  stable_q <= 1'b0;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky interrupt status, set wins over the write-one clear
   assign irq_ev[IRQ_STABLE] = go_stable;
   assign irq_ev[IRQ_RANGE] = sample_ok && (mode_q == SLS_SEMI)
      && (est_st_q == SLS_EST_HOLD) && out_range;
   assign irq_ev[IRQ_SAVED] = timer_save || go_stable || to_manual;
   assign irq_ev[IRQ_UPDATED] = to_manual;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_stat_q <= '0;
      end else if (ce_i) begin
         if (wr_i && addr_i == ADDR_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wdata_i[IRQ_W-1:0]) | irq_ev;
         end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
         end
      end
   end
   assign irq_o = |(irq_stat_q & irq_mask_q);
   assign semi_auto_stable_flag_o = stable_q;

   // read data registered, valid only in the cycle after the strobe
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= 16'h0000;
      end else if (ce_i) begin
         rdata_o <= 16'h0000;
         if (rd_i) begin
            unique case (addr_i)
               ADDR_KP: rdata_o <= kp_q;
               ADDR_KI: rdata_o <= ki_q;
               ADDR_KF: rdata_o <= kf_q;
               ADDR_MODE: rdata_o <= {14'h0, mode_q};
               ADDR_INERTIA: rdata_o <= inertia_q;
               ADDR_STABLE: rdata_o <= {15'h0, stable_q};
               ADDR_STIFF: rdata_o <= stiff_q;
               ADDR_FIRST: rdata_o <= first_q;
               ADDR_LPF: rdata_o <= lpf_q;
               ADDR_EXTRA2: rdata_o <= extra2_q;
               ADDR_STAB_THR: rdata_o <= stab_thr_q;
               ADDR_RANGE_THR: rdata_o <= range_thr_q;
               ADDR_IRQ_STAT: rdata_o <= {12'h0, irq_stat_q};
               ADDR_IRQ_MASK: rdata_o <= {12'h0, irq_mask_q};
               ADDR_EST: rdata_o <= est_q;
               default: rdata_o <= 16'h0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // datapath: tuning modes drive live kp and ki, kf and manual use the registers
   assign gain_bus.kp = manual ? kp_q : auto_kp;
   assign gain_bus.ki = manual ? ki_q : auto_ki;
   assign gain_bus.kf = kf_q;
   assign gain_bus.run = drive_en_i;

   sls_cmd_sel u_cmd_sel (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .drive_en_i(drive_en_i),
      .speed_select_low_i(speed_select_low_i),
      .speed_select_high_i(speed_select_high_i),
      .analog_speed_i(analog_speed_i),
      .selected_speed_command_o(selected_speed_command_o),
      .zero_speed_mode_o(zero_speed_mode_o)
   );

   sls_pi u_pi (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .gain(gain_bus),
      .cmd_i(selected_speed_command_o),
      .fb_i(speed_fb_i),
      .out_o(speed_out_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   mode_range_a: assert property (mode_q != 2'd3) else $error("mode out of range");
   manual_write_a: assert property (wr_ok && manual && addr_i == ADDR_KP
      |=> kp_q == clamp16($past(wdata_i), KP_MAX)) else $error("kp write lost");
   manual_quiet_a: assert property (manual && !(wr_ok && addr_i == ADDR_KI)
      |=> $stable(ki_q)) else $error("ki moved in manual");
   timer_save_a: assert property (timer_save |=> inertia_q == $past(est_q)
      && save_cnt_q == 36'h0) else $error("periodic save missed");
   exit_update_a: assert property (to_manual |=> kp_q == $past(auto_kp)
      && first_q == $past(auto_kp) && inertia_q == $past(est_q)) else $error("exit update");
   semi_exit_a: assert property (to_manual && mode_q == SLS_SEMI
      |=> lpf_q == $past(auto_lpf) && extra2_q == $past(auto_extra2)) else $error("semi exit");
   auto_exit_a: assert property (to_manual && mode_q == SLS_AUTO
      |=> $stable(lpf_q)) else $error("lpf changed on auto exit");
   stable_hold_a: assert property (go_stable |=> stable_q && est_st_q == SLS_EST_HOLD
      && inertia_q == $past(est_q)) else $error("stable hold");
   // estimate must stay frozen while the stable flag holds
   hold_freeze_a: assert property (est_st_q == SLS_EST_HOLD && !mode_wr
      |=> $stable(est_q)) else $error("estimate moved in hold");
   range_resume_a: assert property (irq_ev[IRQ_RANGE] && !mode_wr
      |=> !stable_q && est_st_q == SLS_EST_RUN) else $error("range resume");
   semi_restart_a: assert property (to_semi |=> est_st_q == SLS_EST_RUN && !stable_q
      && est_q == $past(inertia_q)) else $error("semi restart");
   gain_limit_a: assert property (kp_q <= KP_MAX && ki_q <= KI_MAX
      && kf_q <= KF_MAX) else $error("gain limit");
   zero_cmd_a: assert property (ce_i && (!drive_en_i || zero_speed_mode_o == 1'b1
      && !speed_select_low_i && !speed_select_high_i)
      |=> selected_speed_command_o == 16'sh0000) else $error("zero cmd");
   irq_set_a: assert property (ce_i && irq_ev[IRQ_SAVED] |=> irq_stat_q[IRQ_SAVED])
      else $error("save event lost");

   semi_stable_c: cover property (go_stable);
   semi_exit_c: cover property (to_manual && mode_q == SLS_SEMI);
   range_c: cover property (irq_ev[IRQ_RANGE]);
   auto_exit_c: cover property (to_manual && mode_q == SLS_AUTO);
endmodule : sls_tune_top

// *** sim/sls_motor_model.sv ***
// sls_motor_model: far side, speed feedback and inertia estimate samples.
// assumes the bench calls send_sample from its main sequence only.
`timescale 1ns/1ps
module sls_motor_model (
   input wire logic clk_i,
   input wire logic signed [15:0] speed_out_i,
   output logic signed [15:0] speed_fb_o = 16'sh0000,
   output logic [15:0] inertia_sample_o = 16'hffff,
   output logic inertia_valid_o = 1'b0
);
   // load is sluggish: feedback trails the drive output
   always @(posedge clk_i) begin
      speed_fb_o <= speed_out_i >>> 4;
   end
   // one-cycle sample; afterwards the bus shows junk, never the old value
   task automatic send_sample(input logic [15:0] v);
      @(posedge clk_i);
      inertia_sample_o <= v;
      inertia_valid_o <= 1'b1;
      @(posedge clk_i);
      inertia_sample_o <= ~v;
      inertia_valid_o <= 1'b0;
   endtask : send_sample
endmodule : sls_motor_model

// *** sim/tb_speed_loop_gain_tuning.sv ***
// tb_speed_loop_gain_tuning: parameter port, tuning modes and command select.
// assumes the motor model for feedback; save period shortened to 20 cycles.
`timescale 1ns/1ps
module tb_speed_loop_gain_tuning;
   import sls_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic en = 1'b0;
   logic s_lo = 1'b0;
   logic s_hi = 1'b0;
   logic signed [15:0] ana = 16'sh0123;
   logic signed [15:0] spd, fb, cmd;
   logic [15:0] rdata, smp;
   logic vld, zero, flag, irq;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #25 clk_i = ~clk_i;
   sls_tune_top #(.SAVE_CYC(20)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
      .drive_en_i(en), .speed_select_low_i(s_lo), .speed_select_high_i(s_hi),
      .analog_speed_i(ana), .speed_fb_i(fb), .inertia_sample_i(smp), .inertia_valid_i(vld),
      .speed_out_o(spd), .selected_speed_command_o(cmd), .zero_speed_mode_o(zero),
      .semi_auto_stable_flag_o(flag), .irq_o(irq));
   sls_motor_model motor (.clk_i(clk_i), .speed_out_i(spd), .speed_fb_o(fb),
      .inertia_sample_o(smp), .inertia_valid_o(vld));
   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // read data stand only in the cycle after the strobe
   task automatic rc(input logic [11:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk($sformatf("reg %h", a), exp, rdata);
   endtask : rc
   task automatic send(input logic [15:0] v, input int n);
      repeat (n) motor.send_sample(v);
      repeat (2) @(posedge clk_i);
   endtask : send
   task automatic final_report();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   // hang guard, run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      rc(ADDR_KP, KP_RST);
      rc(ADDR_KI, KI_RST);
      wr(ADDR_KP, 16'h3000);
      wr(ADDR_KI, 16'h0500);
      wr(ADDR_KF, 16'h00c8);
      rc(ADDR_KP, 16'h1fff);
      rc(ADDR_KI, 16'h03ff);
      rc(ADDR_KF, 16'h0064);
      wr(ADDR_MODE, 16'h0003);
      rc(ADDR_MODE, 16'h0000);
      rc(12'h7fe, 16'h0000);
      // semi-auto: eight steady samples reach the stable state
      wr(ADDR_INERTIA, 16'h000a);
      wr(ADDR_MODE, 16'h0002);
      wr(ADDR_KP, 16'h0100);
      rc(ADDR_KP, 16'h1fff);
      send(16'h000a, 8);
      chk("flag", 16'h0001, {15'h0, flag});
      rc(ADDR_IRQ_STAT, 16'h0005);
      chk("irq", 16'h0000, {15'h0, irq});
      wr(ADDR_IRQ_MASK, 16'h0001);
      #1 chk("irq", 16'h0001, {15'h0, irq});
      wr(ADDR_IRQ_STAT, 16'h000f);
      #1 chk("irq", 16'h0000, {15'h0, irq});
      // exit to manual: gains from estimate 10 and stiffness 16
      wr(ADDR_MODE, 16'h0000);
      rc(ADDR_KP, 16'h0102);
      rc(ADDR_KI, 16'h0040);
      rc(ADDR_FIRST, 16'h0102);
      rc(ADDR_LPF, 16'h0001);
      rc(ADDR_EXTRA2, 16'h0081);
      rc(ADDR_INERTIA, 16'h000a);
      wr(ADDR_MODE, 16'h0002);
      send(16'h000a, 8);
      chk("flag", 16'h0001, {15'h0, flag});
      send(16'h004b, 1);
      chk("flag", 16'h0000, {15'h0, flag});
      // continuous auto: one sample lifts estimate to 20, timer saves it
      wr(ADDR_MODE, 16'h0000);
      wr(ADDR_INERTIA, 16'h000a);
      wr(ADDR_MODE, 16'h0001);
      send(16'h005a, 1);
      repeat (25) @(posedge clk_i);
      rc(ADDR_INERTIA, 16'h0014);
      wr(ADDR_MODE, 16'h0000);
      rc(ADDR_KP, 16'h0105);
      rc(ADDR_KI, 16'h0041);
      rc(ADDR_LPF, 16'h0001);
      send(16'h0200, 1);
      rc(ADDR_EST, 16'h0014);
      // command select: 00 zero speed, 01 and 10 analog
      @(posedge clk_i);
      en <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk("cmd", 16'h0000, cmd);
      chk("zero", 16'h0001, {15'h0, zero});
      @(posedge clk_i);
      s_lo <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk("cmd", 16'h0123, cmd);
      // first step: kp 261 and kf 100 percent on command 291, feedback and integrator 0
      chk("speed", 16'h024b, spd);
      @(posedge clk_i);
      s_lo <= 1'b0;
      s_hi <= 1'b1;
      ana <= 16'sh0456;
      repeat (2) @(posedge clk_i);
      #1 chk("cmd", 16'h0456, cmd);
      chk("zero", 16'h0000, {15'h0, zero});
      // drive off: command and controller output fall to zero
      @(posedge clk_i);
      en <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1 chk("cmd", 16'h0000, cmd);
      chk("speed", 16'h0000, spd);
      final_report();
   end
endmodule : tb_speed_loop_gain_tuning
